// File: verilog/scard_host_ctrl.sv
/*
 * Smart card host control: host pin latching, card sequencer, card clock, presence/fault line,
 * power-down and recovery, plus a small classic Wishbone register file.
 * Assumes clk_i is the 40 MHz input clock and all pins except the Wishbone port are asynchronous to it.
 */
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ps

// Behaviour
// - Chip select low freezes host control inputs; high lets them act directly.
// - Chip select low: host lines weakly pulled up, no data, fault line released.
// - Mode select low gives asynchronous card mode, high gives synchronous.
// - A falling activate command starts activation only with a card present.
// - Voltage select picks 5 V or 3 V; sequencer switches supply on.
// - Once enabled, card reset equals host reset input in both modes.
// - Asynchronous card clock divides input by 8, 1, 4 or 2 per code.
// - Divided clocks keep 45 to 55 percent duty; rate one follows input.
// - Outside a session and recovery the fault line reports presence only.
// - In session, removal or any fault pulls fault line low and deactivates.
// - Synchronous mode card clock follows strobe; asynchronous mode ignores strobe.
// - Buffered copy of the input clock drives the clock buffer output; it is held low in power-down.
// - Supply over-current starts deactivation and reports a fault.
// - Host or card supply supervisor fault triggers deactivation.
// - Host supply supervisor initialises the sequencer and deactivates at power-off.
// - Power-down request enters low power outside a session only.
// - Presence detection keeps working in power-down, raising the fault line.
// - Normal mode resumes 10 ms after power-down ends; fault line rises then.
// - Activate falls during power-down or recovery are ignored.
// - Deactivation order: reset low, clock stops low, data low, supply off.
// - Asynchronous reset stays low until 42000 card clocks after clock start.
module scard_host_ctrl #(
  parameter int RECOVER_CYC = scard_pkg::RECOVER_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        chip_sel_i,
  input  wire logic        activate_cmd_n_i,
  input  wire logic        voltage_sel_i,
  input  wire logic        host_reset_in_i,
  input  wire logic        power_down_req_i,
  input  wire logic        div_sel_hi_i,
  input  wire logic        div_sel_lo_i,
  input  wire logic        sync_mode_sel_i,
  input  wire logic        strobe_in_i,
  input  wire logic        card_detect_in_i,
  input  wire logic        vdd_fault_i,
  input  wire logic        vcc_fault_i,
  input  wire logic        over_current_i,
  input  wire logic        over_temp_i,
  input  wire logic [2:0]  host_line_i,
  output logic      [2:0]  host_line_o,
  output logic      [2:0]  host_line_oe_o,
  output logic             host_pullup_en_o,
  input  wire logic [2:0]  card_line_i,
  output logic      [2:0]  card_line_o,
  output logic      [2:0]  card_line_oe_o,
  output logic             fault_presence_n_o,
  output logic             fault_presence_n_oe_o,
  output logic             card_clk_o,
  output logic             card_rst_o,
  output logic             vcc_en_o,
  output logic             vcc_5v_o,
  output logic             low_power_state_o,
  output logic             clock_buf_out_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);

  localparam logic [18:0] REC_LOAD  = 19'(RECOVER_CYC);
  localparam logic [15:0] STEP_LOAD = 16'(scard_pkg::STEP_CYC);
  localparam logic [15:0] WAIT_LOAD = 16'(scard_pkg::RST_WAIT_CLKS);

  scard_pkg::scard_state_s r;
  scard_pkg::scard_state_s n;
  scard_pkg::scard_ctl_s   ctl_pins;
  scard_pkg::scard_mon_s   mon_pins;
  logic                    div_clk;
  logic                    tick;
  logic                    card_detect_in;
  logic                    cmd_fall;
  logic                    can_act;
  logic                    in_act;
  logic                    deact_req;
  logic                    sync_mode;
  logic [4:0]              ev;
  logic [31:0]             status;

  // ****************************************************************
  // Pin capture
  // ****************************************************************
  assign ctl_pins = '{activate_cmd_n: activate_cmd_n_i, voltage_sel: voltage_sel_i,
                      host_reset_in: host_reset_in_i, power_down_req: power_down_req_i,
                      div_sel: {div_sel_hi_i, div_sel_lo_i}, sync_mode_sel: sync_mode_sel_i};
  assign mon_pins = '{chip_sel: chip_sel_i, card_detect: card_detect_in_i, strobe: strobe_in_i,
                      vdd_fault: vdd_fault_i, vcc_fault: vcc_fault_i,
                      over_current: over_current_i, over_temp: over_temp_i,
                      host_line: host_line_i, card_line: card_line_i};

  // ****************************************************************
  // Derived conditions
  // ****************************************************************
  assign card_detect_in      = r.mon_s.card_detect;
  assign sync_mode = r.ctl_l.sync_mode_sel;
  assign cmd_fall  = r.cmd_prev && !r.ctl_l.activate_cmd_n;
  assign can_act   = card_detect_in && !r.pd && !r.ctl_l.power_down_req && r.rec_cnt == 19'h0 &&
                     !r.mon_s.vdd_fault && !r.sw_deact;
  assign in_act    = r.seq inside {scard_pkg::SQ_VCC, scard_pkg::SQ_IO, scard_pkg::SQ_RSTW,
                                   scard_pkg::SQ_ACTIVE};
  // The supply fault is only meaningful once the supply had its step to come up.
  assign ev[scard_pkg::FLT_REMOVE] = r.session && !card_detect_in;
  assign ev[scard_pkg::FLT_VDD]    = r.mon_s.vdd_fault;
  assign ev[scard_pkg::FLT_VCC]    = r.mon_s.vcc_fault && r.vcc_en &&
                                     r.seq != scard_pkg::SQ_VCC;
  assign ev[scard_pkg::FLT_OCUR]   = r.mon_s.over_current;
  assign ev[scard_pkg::FLT_TEMP]   = r.mon_s.over_temp;
  assign deact_req = in_act && (r.ctl_l.activate_cmd_n || (|ev) || r.sw_deact);

  assign status = {21'h0, r.vcc_en, sync_mode, r.off_drive, r.rec_cnt != 19'h0, r.pd,
                   card_detect_in, r.session, r.seq};

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n       = r;
    n.ctl_m = ctl_pins;
    n.ctl_s = r.ctl_m;
    n.mon_m = mon_pins;
    n.mon_s = r.mon_m;
    if (r.mon_s.chip_sel) begin
      n.ctl_l = r.ctl_s;
    end
    n.cmd_prev = r.ctl_l.activate_cmd_n;

    // Power-down and recovery.
    n.pd = r.ctl_l.power_down_req && (r.pd || (r.ctl_l.activate_cmd_n && !r.session &&
           r.seq == scard_pkg::SQ_IDLE));
    if (r.mon_s.vdd_fault || (r.pd && !n.pd)) begin
      n.rec_cnt = REC_LOAD;
    end else if (r.rec_cnt != 19'h0) begin
      n.rec_cnt = r.rec_cnt - 19'h1;
    end

    // Sequencer.
    if (r.seq_cnt != 16'h0 && (r.seq != scard_pkg::SQ_RSTW || tick)) begin
      n.seq_cnt = r.seq_cnt - 16'h1;
    end
    if (deact_req) begin
      n.seq     = scard_pkg::SQ_D_RST;
      n.seq_cnt = STEP_LOAD;
    end else begin
      unique case (r.seq)
        scard_pkg::SQ_IDLE: begin
          if (cmd_fall && can_act) begin
            n.seq     = scard_pkg::SQ_VCC;
            n.seq_cnt = STEP_LOAD;
            n.session = 1'b1;
            n.vcc_en  = 1'b1;
            n.v5      = r.ctl_l.voltage_sel;
          end else if (r.ctl_l.activate_cmd_n) begin
            n.session = 1'b0;
          end
        end
        scard_pkg::SQ_VCC: begin
          if (r.seq_cnt == 16'h0) begin
            n.seq     = scard_pkg::SQ_IO;
            n.seq_cnt = STEP_LOAD;
            n.io_en   = 1'b1;
          end
        end
        scard_pkg::SQ_IO: begin
          if (r.seq_cnt == 16'h0) begin
            n.clk_run = 1'b1;
            n.seq_cnt = WAIT_LOAD;
            n.seq     = sync_mode ? scard_pkg::SQ_ACTIVE : scard_pkg::SQ_RSTW;
          end
        end
        scard_pkg::SQ_RSTW: begin
          if (r.seq_cnt == 16'h0) begin
            n.seq = scard_pkg::SQ_ACTIVE;
          end
        end
        scard_pkg::SQ_ACTIVE: begin
          n.seq = scard_pkg::SQ_ACTIVE;
        end
        scard_pkg::SQ_D_RST: begin
          if (r.seq_cnt == 16'h0) begin
            n.seq     = scard_pkg::SQ_D_CLK;
            n.seq_cnt = STEP_LOAD;
            n.clk_run = 1'b0;
          end
        end
        scard_pkg::SQ_D_CLK: begin
          if (r.seq_cnt == 16'h0) begin
            n.seq     = scard_pkg::SQ_D_IO;
            n.seq_cnt = STEP_LOAD;
            n.io_en   = 1'b0;
          end
        end
        scard_pkg::SQ_D_IO: begin
          if (r.seq_cnt == 16'h0) begin
            n.seq     = scard_pkg::SQ_D_VCC;
            n.seq_cnt = STEP_LOAD;
            n.vcc_en  = 1'b0;
          end
        end
        scard_pkg::SQ_D_VCC: begin
          if (r.seq_cnt == 16'h0) begin
            n.seq = scard_pkg::SQ_IDLE;
          end
        end
        default: begin
          n.seq = scard_pkg::SQ_D_RST;
        end
      endcase
    end
    n.card_rst = n.seq == scard_pkg::SQ_ACTIVE && r.ctl_l.host_reset_in;
    n.strb_clk = r.clk_run && r.mon_s.strobe;

    // Presence and fault line; the fault stays reported until the host ends the session.
    if (r.session && |ev) begin
      n.fault_seen = 1'b1;
    end else if (!n.session) begin
      n.fault_seen = 1'b0;
    end
    if (n.session) begin
      n.off_drive = n.fault_seen;
    end else if (r.pd) begin
      n.off_drive = !card_detect_in;
    end else if (r.rec_cnt != 19'h0) begin
      n.off_drive = 1'b1;
    end else begin
      n.off_drive = !card_detect_in;
    end

    // Data lines: with io_en and chip select high, a line pulled low on one side is repeated low on the other.
    for (int i = 0; i < 3; i++) begin
      n.host_oe[i] = r.io_en && r.mon_s.chip_sel && !r.mon_s.card_line[i] && !r.card_oe[i];
      n.card_oe[i] = !r.io_en ||
                     (r.mon_s.chip_sel && !r.mon_s.host_line[i] && !r.host_oe[i]);
    end

    // Register bus; a hardware fault in the clearing cycle keeps its flag.
    n.ack = wb_cyc_i && wb_stb_i && !r.ack;
    if (wb_cyc_i && wb_stb_i && !r.ack) begin
      unique case (wb_adr_i)
        scard_pkg::ADR_STATUS: n.dat = status;
        scard_pkg::ADR_CTRL:   n.dat = {31'h0, r.sw_deact};
        scard_pkg::ADR_FAULT:  n.dat = {27'h0, r.fault_flags};
        default:               n.dat = 32'h0;
      endcase
    end
    if (wb_cyc_i && wb_stb_i && wb_we_i && r.ack && wb_sel_i[0]) begin
      if (wb_adr_i == scard_pkg::ADR_CTRL) begin
        n.sw_deact = wb_dat_i[scard_pkg::CTRL_SWD_BIT];
      end
      if (wb_adr_i == scard_pkg::ADR_FAULT) begin
        n.fault_flags = r.fault_flags & ~wb_dat_i[4:0];
      end
    end
    n.fault_flags = n.fault_flags | (r.session ? ev : 5'h0);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r             <= '0;
      r.ctl_l       <= '{activate_cmd_n: 1'b1, default: 1'b0};
      r.cmd_prev    <= 1'b1;
      r.rec_cnt     <= REC_LOAD;
      r.off_drive   <= 1'b1;
      r.card_oe     <= 3'h7;
      r.sw_deact    <= scard_pkg::CTRL_SWD_RST;
      r.fault_flags <= scard_pkg::FAULT_RST;
    end else begin
      r <= n;
    end
  end

  // ****************************************************************
  // Card clock
  // ****************************************************************
  scard_clkdiv u_div (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .run_i     (r.clk_run && !sync_mode),
    .div_sel_i (r.ctl_l.div_sel),
    .clk_o     (div_clk),
    .tick_o    (tick)
  );

  // At rate one the input clock is gated directly, so its duty cycle passes through; the gate
  // opens and closes just after a rising edge, which may shorten that first or last pulse.
  always_comb begin
    if (sync_mode) begin
      card_clk_o = r.strb_clk;
    end else if (r.ctl_l.div_sel == scard_pkg::DIV_1) begin
      card_clk_o = clk_i && r.clk_run;
    end else begin
      card_clk_o = div_clk;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign clock_buf_out_o       = clk_i && !r.pd;
  assign fault_presence_n_o    = 1'b0;
  assign fault_presence_n_oe_o = r.mon_s.chip_sel && r.off_drive;
  assign host_line_o           = 3'h0;
  assign host_line_oe_o        = r.mon_s.chip_sel ? r.host_oe : 3'h0;
  assign host_pullup_en_o      = !r.mon_s.chip_sel;
  assign card_line_o           = 3'h0;
  assign card_line_oe_o        = r.card_oe;
  assign card_rst_o            = r.card_rst;
  assign vcc_en_o              = r.vcc_en;
  assign vcc_5v_o              = r.v5;
  assign low_power_state_o     = r.pd;
  assign wb_dat_o              = r.dat;
  assign wb_ack_o              = r.ack;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_deact_start;
    r.seq inside {scard_pkg::SQ_RSTW, scard_pkg::SQ_ACTIVE} ##1 r.seq == scard_pkg::SQ_D_RST;
  endsequence

  property p_cs_release;
    !r.mon_s.chip_sel |-> !fault_presence_n_oe_o && host_pullup_en_o && host_line_oe_o == 3'h0;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("chip select low not released");

  property p_deact_order;
    s_deact_start |-> !card_rst_o && r.clk_run && r.io_en && r.vcc_en;
  endproperty
  a_deact_order: assert property (p_deact_order) else $error("deactivation order broken");

  property p_no_act_pd;
    r.seq == scard_pkg::SQ_IDLE && (r.pd || r.rec_cnt != 19'h0) |=> r.seq == scard_pkg::SQ_IDLE;
  endproperty
  a_no_act_pd: assert property (p_no_act_pd) else $error("activation during power-down");

  property p_rst_wait;
    r.seq == scard_pkg::SQ_RSTW || r.seq == scard_pkg::SQ_IO |-> !card_rst_o;
  endproperty
  a_rst_wait: assert property (p_rst_wait) else $error("card reset raised too early");

  property p_rst_follow;
    (r.seq == scard_pkg::SQ_ACTIVE) [*2] |-> card_rst_o == $past(r.ctl_l.host_reset_in);
  endproperty
  a_rst_follow: assert property (p_rst_follow) else $error("card reset not following host");

  property p_fault_deact;
    in_act && (|ev) |=> r.seq == scard_pkg::SQ_D_RST ##1 fault_presence_n_oe_o || !r.mon_s.chip_sel;
  endproperty
  a_fault_deact: assert property (p_fault_deact) else $error("fault did not deactivate");

  property p_presence;
    !r.session && !n.session && !r.pd && r.rec_cnt == 19'h0 && $stable(card_detect_in) && r.mon_s.chip_sel
    |=> fault_presence_n_oe_o == !$past(card_detect_in);
  endproperty
  a_presence: assert property (p_presence) else $error("presence report wrong");

  property p_pd_entry;
    r.ctl_l.power_down_req && r.ctl_l.activate_cmd_n && !r.session &&
    r.seq == scard_pkg::SQ_IDLE |=> low_power_state_o;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

  property p_recover;
    $fell(r.pd) && !r.mon_s.vdd_fault |-> r.rec_cnt == REC_LOAD && !r.session;
  endproperty
  a_recover: assert property (p_recover) else $error("recovery interval not started");

endmodule

// File: verilog/scard_pkg.sv
/*
 * Shared constants, types and the state records for the smart card host control block.
 * Assumes a 40 MHz system clock that is also the card reference clock.
 */
package scard_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ       = 40;
  localparam int T_STEP_NS     = 1000;
  localparam int STEP_CYC      = (T_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RECOVER_MS  = 10;
  localparam int RECOVER_CYC   = T_RECOVER_MS * CLK_MHZ * 1000;
  localparam int RST_WAIT_CLKS = 42000;

  // ****************************************************************
  // Clock division codes, high select bit first
  // ****************************************************************
  localparam logic [1:0] DIV_8 = 2'h0;
  localparam logic [1:0] DIV_1 = 2'h1;
  localparam logic [1:0] DIV_4 = 2'h2;
  localparam logic [1:0] DIV_2 = 2'h3;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  ADR_STATUS   = 8'h00;
  localparam logic [7:0]  ADR_CTRL     = 8'h04;
  localparam logic [7:0]  ADR_FAULT    = 8'h08;
  localparam int          CTRL_SWD_BIT = 0;
  localparam logic        CTRL_SWD_RST = 1'b0;
  localparam logic [4:0]  FAULT_RST    = 5'h00;
  localparam int          FLT_REMOVE   = 0;
  localparam int          FLT_VDD      = 1;
  localparam int          FLT_VCC      = 2;
  localparam int          FLT_OCUR     = 3;
  localparam int          FLT_TEMP     = 4;
  localparam int          ST_SEQ_LSB   = 0;
  localparam int          ST_SESSION   = 4;
  localparam int          ST_PRESENT   = 5;
  localparam int          ST_LOWPWR    = 6;
  localparam int          ST_RECOVER   = 7;
  localparam int          ST_OFFLOW    = 8;
  localparam int          ST_SYNC      = 9;
  localparam int          ST_VCCEN     = 10;

  typedef enum logic [3:0] {
    SQ_IDLE, SQ_VCC, SQ_IO, SQ_RSTW, SQ_ACTIVE, SQ_D_RST, SQ_D_CLK, SQ_D_IO, SQ_D_VCC
  } scard_seq_e;

  // Host control inputs that chip select freezes.
  typedef struct packed {
    logic       activate_cmd_n;
    logic       voltage_sel;
    logic       host_reset_in;
    logic       power_down_req;
    logic [1:0] div_sel;
    logic       sync_mode_sel;
  } scard_ctl_s;

  // Monitored pins that are never frozen.
  typedef struct packed {
    logic       chip_sel;
    logic       card_detect;
    logic       strobe;
    logic       vdd_fault;
    logic       vcc_fault;
    logic       over_current;
    logic       over_temp;
    logic [2:0] host_line;
    logic [2:0] card_line;
  } scard_mon_s;

  typedef struct packed {
    scard_ctl_s  ctl_m;
    scard_ctl_s  ctl_s;
    scard_mon_s  mon_m;
    scard_mon_s  mon_s;
    scard_ctl_s  ctl_l;
    logic        cmd_prev;
    scard_seq_e  seq;
    logic [15:0] seq_cnt;
    logic [18:0] rec_cnt;
    logic        session;
    logic        fault_seen;
    logic        pd;
    logic        vcc_en;
    logic        v5;
    logic        io_en;
    logic        clk_run;
    logic        strb_clk;
    logic        card_rst;
    logic        off_drive;
    logic [2:0]  host_oe;
    logic [2:0]  card_oe;
    logic        sw_deact;
    logic [4:0]  fault_flags;
    logic        ack;
    logic [31:0] dat;
  } scard_state_s;

  typedef struct packed {
    logic [2:0] cnt;
    logic       clk_q;
    logic       tick;
  } scard_div_s;

endpackage

// File: verilog/scard_clkdiv.sv
/*
 * Card clock divider: makes the divided card clock and a tick per card clock cycle.
 * Assumes run_i and div_sel_i come from flip-flops on the same clock.
 */
`timescale 1ns/1ps

module scard_clkdiv (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       run_i,
  input  wire logic [1:0] div_sel_i,
  output logic            clk_o,
  output logic            tick_o
);

  scard_pkg::scard_div_s r;
  scard_pkg::scard_div_s n;

  function automatic logic div_bit(input logic [1:0] sel, input logic [2:0] cnt);
    unique case (sel)
      scard_pkg::DIV_8: div_bit = cnt[2];
      scard_pkg::DIV_4: div_bit = cnt[1];
      scard_pkg::DIV_2: div_bit = cnt[0];
      scard_pkg::DIV_1: div_bit = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // Divider
  // ****************************************************************
  // A counter bit toggles every half period, so each divided clock is exactly 50 percent.
  always_comb begin
    n       = r;
    n.cnt   = run_i ? r.cnt + 3'h1 : 3'h0;
    n.clk_q = run_i && div_bit(div_sel_i, n.cnt);
    n.tick  = run_i && ((div_sel_i == scard_pkg::DIV_1) || (n.clk_q && !r.clk_q));
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign clk_o  = r.clk_q;
  assign tick_o = r.tick;

  property p_half_high;
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(r.clk_q) && run_i && div_sel_i == scard_pkg::DIV_4 && $stable(div_sel_i)
    |=> r.clk_q ##1 !r.clk_q || !run_i;
  endproperty
  a_half_high: assert property (p_half_high) else $error("quarter rate high phase wrong");

endmodule

// File: testbench/scard_card_model.sv
/*
 * Card side model: presence switch and open-drain card lines with pull-ups.
 * Assumes the host block pulls a card line low while its enable is high.
 */
`timescale 1ns/1ps

module scard_card_model (
  input  wire logic       insert_i,
  input  wire logic       pull_i,
  input  wire logic [2:0] line_oe_i,
  output logic            present_o,
  output logic      [2:0] line_o
);
  // A released line reads high unless pull_i pulls line 0 low, never the last driven value.
  assign line_o    = ~line_oe_i & {2'h3, ~pull_i};
  assign present_o = insert_i;
endmodule

// File: testbench/tb.sv
/*
 * Testbench for the smart card host control block with a shortened recovery count.
 * Assumes the card model stands on the card side and the bench plays the host.
 */
`timescale 1ns/1ps

module tb;
  localparam int RC = 200;
  logic clk_i = 0, resetn_i = 0, cs = 0, cmd_n = 1, vsel = 0, hrst = 0, pd = 0, ins = 1;
  logic sync = 1, strb = 0, hpull = 0, cpull = 0, cyc = 0, stb = 0, we = 0;
  logic [1:0] div = 2'h1;
  logic [3:0] flt = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [2:0] hoe, coe, cline;
  logic ack, present, fpoe, pue, cclk, crst, vcc, v5, lp, cbuf;
  int n_mismatch = 0, cmp_count = 0;

  always #12.5 clk_i = ~clk_i;

  scard_card_model scard_card_model_inst (.insert_i(ins), .pull_i(cpull), .line_oe_i(coe),
    .present_o(present), .line_o(cline));

  scard_host_ctrl #(.RECOVER_CYC(RC)) scard_host_ctrl_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .chip_sel_i(cs), .activate_cmd_n_i(cmd_n), .voltage_sel_i(vsel), .host_reset_in_i(hrst),
    .power_down_req_i(pd), .div_sel_hi_i(div[1]), .div_sel_lo_i(div[0]),
    .sync_mode_sel_i(sync), .strobe_in_i(strb), .card_detect_in_i(present),
    .vdd_fault_i(flt[0]), .vcc_fault_i(flt[1]), .over_current_i(flt[2]),
    .over_temp_i(flt[3]), .host_line_i({2'h3, ~hpull} & ~hoe), .host_line_o(),
    .host_line_oe_o(hoe), .host_pullup_en_o(pue), .card_line_i(cline), .card_line_o(),
    .card_line_oe_o(coe), .fault_presence_n_o(), .fault_presence_n_oe_o(fpoe),
    .card_clk_o(cclk), .card_rst_o(crst), .vcc_en_o(vcc), .vcc_5v_o(v5),
    .low_power_state_o(lp), .clock_buf_out_o(cbuf), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic single cycle: request held until ack is sampled, then released.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int t = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && ++t < 50);
    q = rdat;
    if (t >= 50) n_mismatch++;
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    wrap_up;
  end

  initial begin
    logic [31:0] q;
    int hi, rise;
    logic prev;
    cyc_n(12);
    resetn_i <= 1;
    cs <= 1;
    wb(0, scard_pkg::ADR_CTRL, 0, q);
    chk("ctrl reset", 32'h0, q);
    wb(0, 8'h0c, 0, q);
    chk("unmapped", 32'h0, q);
    chk("recovery line", 1, fpoe);
    cmd_n <= 0;
    cyc_n(10);
    chk("vcc in recovery", 0, vcc);
    cmd_n <= 1;
    cyc_n(RC + 10);
    chk("presence", 0, fpoe);
    cs <= 0;
    ins <= 0;
    cyc_n(5);
    chk("line released", 0, fpoe);
    chk("pull-up", 1, pue);
    ins <= 1;
    cmd_n <= 0;
    cyc_n(10);
    chk("latched cmd", 0, vcc);
    cs <= 1;
    cyc_n(10);
    chk("edge at release", 1, vcc);
    cmd_n <= 1;
    cyc_n(180);
    for (int f = 0; f < 5; f++) begin
      vsel <= f[0];
      hrst <= 1;
      cyc_n(4);
      cmd_n <= 0;
      cyc_n(6);
      chk("vcc_en", 1, vcc);
      chk("vcc_5v", f[0], v5);
      cyc_n(90);
      chk("card_rst", 1, crst);
      hpull <= 1;
      cyc_n(5);
      chk("card data", 1, coe[0]);
      hpull <= 0;
      cpull <= 1;
      strb <= 1;
      cyc_n(6);
      chk("host data", 1, hoe[0]);
      chk("strobe clk", 1, cclk);
      cpull <= 0;
      if (f < 4) flt <= 4'h1 << f;
      else ins <= 0;
      cyc_n(5);
      chk("fault line", 1, fpoe);
      chk("rst low", 0, crst);
      cyc_n(45);
      chk("clk stopped", 0, cclk);
      cyc_n(40);
      chk("lines low", 7, coe);
      chk("vcc held", 1, vcc);
      cyc_n(40);
      chk("vcc off", 0, vcc);
      flt <= 0;
      cmd_n <= 1;
      strb <= 0;
      cyc_n(RC + 20);
      chk("presence after", f == 4, fpoe);
      ins <= 1;
      cyc_n(4);
    end
    sync <= 0;
    for (int c = 0; c < 4; c++) begin
      div <= c[1:0];
      cyc_n(4);
      cmd_n <= 0;
      cyc_n(100);
      hi = 0;
      rise = 0;
      for (int k = 0; k <= 64; k++) begin
        @(posedge clk_i);
        strb <= k[0];
        #1;
        if (k > 0) begin
          hi += cclk;
          rise += (cclk && !prev) ? 1 : 0;
        end
        prev = cclk;
      end
      chk("clock buffer high", 1, cbuf);
      @(negedge clk_i);
      chk("clock buffer low", 0, cbuf);
      if (c == 1) chk("rate one low", 0, cclk);
      @(posedge clk_i);
      chk("duty", c == 1 ? 64 : 32, hi);
      chk("divide", c == 0 ? 8 : c == 1 ? 0 : c == 2 ? 16 : 32, rise);
      chk("async rst wait", 0, crst);
      cmd_n <= 1;
      cyc_n(180);
    end
    pd <= 1;
    ins <= 0;
    cyc_n(6);
    chk("low power", 1, lp);
    #1;
    chk("clock buffer stopped", 0, cbuf);
    cyc_n(1);
    ins <= 1;
    cyc_n(6);
    chk("insert in pd", 0, fpoe);
    cmd_n <= 0;
    cyc_n(10);
    chk("pd refuse", 0, vcc);
    chk("pd held", 1, lp);
    cmd_n <= 1;
    pd <= 0;
    cyc_n(20);
    chk("pd recovery", 1, fpoe);
    cyc_n(RC);
    chk("pd resumed", 0, fpoe);
    cmd_n <= 0;
    cyc_n(6);
    chk("activate after recovery", 1, vcc);
    wrap_up;
  end
endmodule
